// ---- src/dima_pkg.sv ----
package dima_pkg;

  // ----------------------------------------------------------------
  // geometry
  // ----------------------------------------------------------------
  localparam int ROWS = 5;
  localparam int BYTE_LANES = 8;
  localparam int MA_W = 12;
  localparam int ATTR_REGIONS = 7;
  localparam int MB_SHIFT = 20;
  localparam int ATTR_SEG_SHIFT = 15;
  localparam logic [7:0] MAX_MEM_MB = 8'h80;

  // ----------------------------------------------------------------
  // memory map
  // ----------------------------------------------------------------
  localparam logic [31:0] HOLE_LO_BASE = 32'h0008_0000;
  localparam logic [31:0] SMM_BASE = 32'h000A_0000;
  localparam logic [31:0] ATTR_BASE = 32'h000C_0000;
  localparam logic [31:0] ATTR_TOP_BASE = 32'h000F_0000;
  localparam logic [31:0] ONE_MB = 32'h0010_0000;
  localparam logic [31:0] HOLE_HI_BASE = 32'h00F0_0000;
  localparam logic [31:0] HOLE_HI_END = 32'h0100_0000;

  localparam logic [1:0] HOLE_NONE = 2'h0;
  localparam logic [1:0] HOLE_LOW = 2'h1;
  localparam logic [1:0] HOLE_HIGH = 2'h2;

  localparam int ATTR_RD_BIT = 0;
  localparam int ATTR_WR_BIT = 1;
  localparam int ATTR_CACHE_BIT = 2;

  localparam logic [1:0] SMM_DISABLED = 2'h0;
  localparam logic [1:0] SMM_CLOSED = 2'h1;
  localparam logic [1:0] SMM_OPEN = 2'h2;
  localparam logic [1:0] SMM_LOCKED = 2'h3;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 50;
  localparam int REFRESH_PERIOD_NS = 15600000;
  localparam int REFRESH_CYCLES = REFRESH_PERIOD_NS / CLK_PERIOD_NS;
  localparam int RAS_PRECHARGE_NS = 60;
  localparam int REF_RAS_NS = 60;
  localparam int RCD_BASE_NS = 20;
  localparam int CAS_EDO_NS = 25;
  localparam int CAS_PAGE_NS = 60;
  localparam logic [3:0] RP_CYC =
    4'((RAS_PRECHARGE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [3:0] REF_RAS_CYC =
    4'((REF_RAS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [3:0] RCD_CYC =
    4'((RCD_BASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [3:0] CAS_EDO_CYC =
    4'((CAS_EDO_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [3:0] CAS_PAGE_CYC =
    4'((CAS_PAGE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam int REF_TIMER_W = 19;
  localparam logic [2:0] REF_QUEUE_DEPTH = 3'h4;

  typedef enum logic [2:0]
  {
    ST_IDLE,
    ST_RAS,
    ST_CAS,
    ST_PRE,
    ST_REF,
    ST_REF_PRE
  } dima_state_type;

endpackage

// ---- src/dima_controller.sv ----
module dima_controller
  import dima_pkg::*;
#(
  parameter int REFRESH_CYCLES_P = REFRESH_CYCLES
)
(
  input wire logic CLK,
  input wire logic RESET_N,
  input wire logic ACCESS_REQ,
  input wire logic [31:0] ACCESS_ADDR,
  input wire logic ACCESS_WRITE,
  input wire logic ACCESS_PCI,
  input wire logic [7:0] ACCESS_BE,
  output logic ACCESS_READY,
  output logic ACCESS_DONE,
  output logic FORWARD_PCI,
  output logic NON_CACHEABLE,
  input wire logic [7:0] ROW_BOUNDARY0,
  input wire logic [7:0] ROW_BOUNDARY1,
  input wire logic [7:0] ROW_BOUNDARY2,
  input wire logic [7:0] ROW_BOUNDARY3,
  input wire logic [7:0] ROW_BOUNDARY4,
  input wire logic [4:0] ROW_TYPE,
  input wire logic [1:0] RAS_TIMING,
  input wire logic [1:0] CAS_RATE,
  input wire logic [1:0] HOLE_SEL,
  input wire logic [2:0] ATTRIBUTE_MAP0,
  input wire logic [2:0] ATTRIBUTE_MAP1,
  input wire logic [2:0] ATTRIBUTE_MAP2,
  input wire logic [2:0] ATTRIBUTE_MAP3,
  input wire logic [2:0] ATTRIBUTE_MAP4,
  input wire logic [2:0] ATTRIBUTE_MAP5,
  input wire logic [2:0] ATTRIBUTE_MAP6,
  input wire logic [1:0] SYSTEM_MGMT_MEMORY_CTRL,
  input wire logic SMM_ACTIVE,
  output logic SMM_LOCKED_STATUS,
  output logic [2:0] REFRESH_PENDING,
  output logic [4:0] BOARD_ROW_STROBE_N,
  output logic [7:0] COL_STROBE_N,
  output logic MEMORY_OUTPUT_ENABLE_N,
  output logic [11:0] MUX_MEM_ADDR
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed
  {
    // sequencer
    dima_state_type state;
    logic [3:0] cnt;
    // access latched when taken
    logic wr;
    logic [7:0] be;
    logic extended_output_dram;
    logic [11:0] col_addr;
    // pins
    logic [4:0] ras_n;
    logic [7:0] cas_n;
    logic moe_n;
    logic [11:0] ma;
    // refresh bookkeeping
    logic [2:0] ref_count;
    logic [REF_TIMER_W-1:0] ref_timer;
    logic [11:0] ref_addr;
    // status
    logic smm_lock;
    logic done;
    logic fwd;
    logic noncache;
  } dima_regs_type;

  dima_regs_type r;
  dima_regs_type next_r;

  logic [7:0] bound [ROWS];
  logic [2:0] attr [ATTR_REGIONS];

  assign bound[0] = ROW_BOUNDARY0;
  assign bound[1] = ROW_BOUNDARY1;
  assign bound[2] = ROW_BOUNDARY2;
  assign bound[3] = ROW_BOUNDARY3;
  assign bound[4] = ROW_BOUNDARY4;
  assign attr[0] = ATTRIBUTE_MAP0;
  assign attr[1] = ATTRIBUTE_MAP1;
  assign attr[2] = ATTRIBUTE_MAP2;
  assign attr[3] = ATTRIBUTE_MAP3;
  assign attr[4] = ATTRIBUTE_MAP4;
  assign attr[5] = ATTRIBUTE_MAP5;
  assign attr[6] = ATTRIBUTE_MAP6;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [7:0] clamp_mb(input logic [7:0] b);
    clamp_mb = (b > MAX_MEM_MB) ? MAX_MEM_MB : b;
  endfunction

  function automatic logic [11:0] row_addr(input logic [31:0] a);
    row_addr = {a[24], a[23], a[21], a[20], a[19:12]};
  endfunction

  function automatic logic [11:0] col_addr(input logic [31:0] a);
    // unused top bit driven low; devices ignore it in column phase
    col_addr = {1'b0, a[24], a[22], a[11:3]};
  endfunction

  function automatic logic [3:0] dec(input logic [3:0] c);
    dec = (c != 4'h0) ? c - 4'h1 : 4'h0;
  endfunction

  // byte address of a boundary given in megabytes, after the cap
  function automatic logic [31:0] mb_addr(input logic [7:0] b);
    mb_addr = 32'(clamp_mb(b)) << MB_SHIFT;
  endfunction

  function automatic logic in_range(input logic [31:0] a,
    input logic [31:0] lo, input logic [31:0] hi);
    in_range = (a >= lo) && (a < hi);
  endfunction

  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------
  logic [31:0] top_addr;
  logic [4:0] row_hit;
  logic [4:0] populated;
  logic [2:0] attr_idx;
  logic [2:0] attr_sel;
  logic [1:0] smm_mode;
  logic smm_ok;
  logic dec_fwd;
  logic dec_nc;
  logic dec_edo;
  logic queue_full;

  always_comb
  begin
    top_addr = mb_addr(bound[ROWS-1]);
    row_hit = 5'h00;
    for (int i = 0; i < ROWS; i++)
    begin
      // cumulative boundaries; first one above the address wins
      if (row_hit == 5'h00 && ACCESS_ADDR < mb_addr(bound[i]))
        row_hit[i] = 1'b1;
    end
    // bank zero is refreshed even when its boundary reads empty
    populated = 5'h01;
    for (int i = 1; i < ROWS; i++)
    begin
      if (clamp_mb(bound[i]) > clamp_mb(bound[i-1]))
        populated[i] = 1'b1;
    end
    // mixed rows: the hit row's own ROW_TYPE bit picks EDO or page-mode column timing
    dec_edo = |(ROW_TYPE & row_hit);
  end

  // ----------------------------------------------------------------
  // memory map decode
  // ----------------------------------------------------------------
  always_comb
  begin
    // index wraps outside the attribute area; only used inside it
    attr_idx = (ACCESS_ADDR >= ATTR_TOP_BASE) ? 3'h0
      : 3'h1 + ACCESS_ADDR[ATTR_SEG_SHIFT+2:ATTR_SEG_SHIFT];
    attr_sel = (attr_idx < 3'(ATTR_REGIONS)) ? attr[attr_idx] : 3'h0;
    // a lock written this cycle already behaves as closed
    smm_mode = (r.smm_lock || SYSTEM_MGMT_MEMORY_CTRL == SMM_LOCKED)
      ? SMM_CLOSED : SYSTEM_MGMT_MEMORY_CTRL;
    smm_ok = !ACCESS_PCI && (smm_mode == SMM_OPEN
      || (smm_mode == SMM_CLOSED && SMM_ACTIVE));
    dec_fwd = 1'b0;
    dec_nc = 1'b0;
    if (ACCESS_ADDR >= top_addr)
      dec_fwd = 1'b1;
    else if (HOLE_SEL == HOLE_LOW
      && in_range(ACCESS_ADDR, HOLE_LO_BASE, SMM_BASE))
      dec_fwd = 1'b1;
    else if (HOLE_SEL == HOLE_HIGH
      && in_range(ACCESS_ADDR, HOLE_HI_BASE, HOLE_HI_END))
      dec_fwd = 1'b1;
    else if (in_range(ACCESS_ADDR, SMM_BASE, ATTR_BASE))
    begin
      // video buffer unless the management window maps it to DRAM
      dec_fwd = !smm_ok;
      dec_nc = 1'b1;
    end
    else if (in_range(ACCESS_ADDR, ATTR_BASE, ONE_MB))
    begin
      dec_fwd = ACCESS_WRITE ? !attr_sel[ATTR_WR_BIT]
        : !attr_sel[ATTR_RD_BIT];
      dec_nc = !attr_sel[ATTR_CACHE_BIT];
    end
    // everything else below top stays DRAM and cacheable
    if (dec_fwd)
      dec_nc = 1'b1;
    // a full queue outranks any waiting access
    queue_full = (r.ref_count == REF_QUEUE_DEPTH);
  end

  // requests are held off while refresh has taken top priority
  assign ACCESS_READY = (r.state == ST_IDLE) && !queue_full;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  logic ref_tick;
  logic ref_start;

  always_comb
  begin
    next_r = r;
    next_r.done = 1'b0;
    ref_start = 1'b0;
    next_r.smm_lock = r.smm_lock
      || (SYSTEM_MGMT_MEMORY_CTRL == SMM_LOCKED);
    ref_tick = (r.ref_timer == REF_TIMER_W'(REFRESH_CYCLES_P - 1));
    next_r.ref_timer = ref_tick ? '0 : r.ref_timer + 1'b1;
    unique case (r.state)
      ST_IDLE:
      begin
        if (queue_full || (!ACCESS_REQ && r.ref_count != 3'h0))
        begin
          ref_start = 1'b1;
          next_r.ras_n = ~populated;
          next_r.ma = r.ref_addr;
          // row counter wraps; twelve bits cover the deepest device
          next_r.ref_addr = r.ref_addr + 12'h001;
          next_r.cnt = dec(REF_RAS_CYC);
          next_r.state = ST_REF;
        end
        else if (ACCESS_REQ)
        begin
          next_r.fwd = dec_fwd;
          next_r.noncache = dec_nc;
          if (dec_fwd)
            next_r.done = 1'b1;
          else
          begin
            next_r.ras_n = ~row_hit;
            next_r.ma = row_addr(ACCESS_ADDR);
            next_r.col_addr = col_addr(ACCESS_ADDR);
            next_r.wr = ACCESS_WRITE;
            next_r.be = ACCESS_BE;
            next_r.extended_output_dram = dec_edo;
            next_r.cnt = dec(RCD_CYC + {2'b00, RAS_TIMING});
            next_r.state = ST_RAS;
          end
        end
      end
      ST_RAS:
      begin
        next_r.cnt = dec(r.cnt);
        if (r.cnt == 4'h0)
        begin
          // reads open every lane; writes only the enabled bytes
          next_r.cas_n = r.wr ? ~r.be : 8'h00;
          next_r.ma = r.col_addr;
          next_r.moe_n = !r.wr;
          next_r.cnt = dec((r.extended_output_dram ? CAS_EDO_CYC : CAS_PAGE_CYC)
            + {2'b00, CAS_RATE});
          next_r.state = ST_CAS;
        end
      end
      ST_CAS:
      begin
        next_r.cnt = dec(r.cnt);
        if (r.cnt == 4'h0)
        begin
          next_r.cas_n = 8'hFF;
          next_r.ras_n = 5'h1F;
          next_r.moe_n = 1'b1;
          next_r.done = 1'b1;
          next_r.cnt = dec(RP_CYC);
          next_r.state = ST_PRE;
        end
      end
      ST_REF:
      begin
        // row-strobe-only cycle: no column phase follows
        next_r.cnt = dec(r.cnt);
        if (r.cnt == 4'h0)
        begin
          next_r.ras_n = 5'h1F;
          next_r.cnt = dec(RP_CYC);
          next_r.state = ST_REF_PRE;
        end
      end
      ST_PRE, ST_REF_PRE:
      begin
        next_r.cnt = dec(r.cnt);
        if (r.cnt == 4'h0)
          next_r.state = ST_IDLE;
      end
      default:
      begin
        // an unreachable code parks the pins idle and restarts
        next_r.state = ST_IDLE;
        next_r.ras_n = 5'h1F;
        next_r.cas_n = 8'hFF;
        next_r.moe_n = 1'b1;
      end
    endcase
    // a tick while full is dropped unless a refresh starts in that cycle; rate is slow enough to never lose
    // one unless refresh is starved by the full-priority path itself
    if (ref_tick && !ref_start && !queue_full)
      next_r.ref_count = r.ref_count + 3'h1;
    else if (ref_start && !ref_tick)
      next_r.ref_count = r.ref_count - 3'h1;
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge CLK)
  begin
    if (!RESET_N)
    begin
      r <= '0;
      r.state <= ST_IDLE;
      r.ras_n <= 5'h1F;
      r.cas_n <= 8'hFF;
      r.moe_n <= 1'b1;
    end
    else
      r <= next_r;
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign ACCESS_DONE = r.done;
  assign FORWARD_PCI = r.fwd;
  assign NON_CACHEABLE = r.noncache;
  assign SMM_LOCKED_STATUS = r.smm_lock;
  assign REFRESH_PENDING = r.ref_count;
  assign BOARD_ROW_STROBE_N = r.ras_n;
  assign COL_STROBE_N = r.cas_n;
  assign MEMORY_OUTPUT_ENABLE_N = r.moe_n;
  assign MUX_MEM_ADDR = r.ma;

endmodule

// ---- tb/dima_properties.sv ----
module dima_properties
  import dima_pkg::*;
(
  input wire logic CLK,
  input wire logic RESET_N,
  input wire logic ACCESS_REQ,
  input wire logic ACCESS_READY,
  input wire logic ACCESS_DONE,
  input wire logic [4:0] BOARD_ROW_STROBE_N,
  input wire logic [7:0] COL_STROBE_N,
  input wire logic MEMORY_OUTPUT_ENABLE_N,
  input wire logic [2:0] REFRESH_PENDING,
  input wire logic [1:0] SYSTEM_MGMT_MEMORY_CTRL,
  input wire logic SMM_LOCKED_STATUS
);
  timeunit 1ns;
  timeprecision 1ns;
  // ----
  // checks
  // ----
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RESET_N);
  done_pulse_a: assert property (
    ACCESS_DONE && !(ACCESS_REQ && ACCESS_READY) |=> !ACCESS_DONE)
    else $error("done too long");
  take_done_a: assert property (
    ACCESS_REQ && ACCESS_READY |-> ##[1:12] ACCESS_DONE)
    else $error("no done");
  precharge_a: assert property (
    $rose(&BOARD_ROW_STROBE_N) |-> !ACCESS_READY [*2])
    else $error("no precharge");
  col_in_row_a: assert property (
    !(&COL_STROBE_N) |-> !(&BOARD_ROW_STROBE_N))
    else $error("column without row");
  write_col_a: assert property (
    !MEMORY_OUTPUT_ENABLE_N |-> !(&COL_STROBE_N))
    else $error("write outside column");
  queue_cap_a: assert property (REFRESH_PENDING <= 3'h4)
    else $error("queue over four");
  full_block_a: assert property (
    REFRESH_PENDING == 3'h4 |-> !ACCESS_READY)
    else $error("ready with full queue");
  full_serve_a: assert property (
    REFRESH_PENDING == 3'h4 |-> ##[1:16] REFRESH_PENDING != 3'h4)
    else $error("full queue not served");
  lock_set_a: assert property (
    SYSTEM_MGMT_MEMORY_CTRL == SMM_LOCKED |=> SMM_LOCKED_STATUS)
    else $error("lock not seen");
  lock_hold_a: assert property (
    SMM_LOCKED_STATUS |=> SMM_LOCKED_STATUS)
    else $error("lock dropped");
  write_c: cover property (!MEMORY_OUTPUT_ENABLE_N);
  full_c: cover property (REFRESH_PENDING == 3'h4);
  lock_c: cover property (SMM_LOCKED_STATUS);
endmodule

bind dima_controller dima_properties chk_u (.*);

// ---- tb/dima_dram_model.sv ----
module dima_dram_model
(
  input wire logic clk,
  input wire logic [4:0] row_n,
  input wire logic [7:0] col_n,
  input wire logic oe_n,
  input wire logic [11:0] ma,
  output logic [4:0] rows,
  output logic [11:0] row_addr,
  output logic [11:0] col_addr,
  output logic [7:0] lanes,
  output logic wr,
  output logic [4:0] ref_rows = 5'h00,
  output int refreshes = 0
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [4:0] last_n = 5'h1F;
  logic [7:0] last_col_n = 8'hFF;
  logic cas_seen = 1'b0;
  // ----
  // capture of each strobe phase
  // ----
  always @(posedge clk)
  begin
    last_n <= row_n;
    last_col_n <= col_n;
    if (&last_n && !(&row_n))
    begin
      rows <= ~row_n;
      row_addr <= ma;
      cas_seen <= 1'b0;
    end
    if (&last_col_n && !(&col_n))
    begin
      col_addr <= ma;
      lanes <= ~col_n;
      wr <= ~oe_n;
      cas_seen <= 1'b1;
    end
    // row phase closed with no column phase: refresh only
    if (!(&last_n) && &row_n && !cas_seen)
    begin
      refreshes <= refreshes + 1;
      ref_rows <= ref_rows | ~last_n;
    end
  end
endmodule

// ---- tb/tb.sv ----
module tb;
  import dima_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic CLK = 1'b0, RESET_N = 1'b0, ACCESS_REQ = 1'b0, ACCESS_WRITE = 1'b0;
  logic ACCESS_PCI = 1'b0, SMM_ACTIVE = 1'b0, full = 1'b0;
  logic [31:0] ACCESS_ADDR = 32'h0, a;
  logic [7:0] ACCESS_BE = 8'hFF, ROW_BOUNDARY0 = 8'h08, ROW_BOUNDARY1 = 8'h10;
  logic [7:0] ROW_BOUNDARY2 = 8'h10, ROW_BOUNDARY3 = 8'h20;
  logic [7:0] ROW_BOUNDARY4 = 8'h40;
  logic [4:0] ROW_TYPE = 5'h01;
  logic [1:0] RAS_TIMING = 2'h0, CAS_RATE = 2'h0, HOLE_SEL = 2'h0;
  logic [1:0] SYSTEM_MGMT_MEMORY_CTRL = 2'h0;
  logic [2:0] ATTRIBUTE_MAP0 = 3'h7, ATTRIBUTE_MAP1 = 3'h7;
  logic [2:0] ATTRIBUTE_MAP2 = 3'h7, ATTRIBUTE_MAP3 = 3'h7;
  logic [2:0] ATTRIBUTE_MAP4 = 3'h7, ATTRIBUTE_MAP5 = 3'h7;
  logic [2:0] ATTRIBUTE_MAP6 = 3'h7, REFRESH_PENDING;
  logic ACCESS_READY, ACCESS_DONE, FORWARD_PCI, NON_CACHEABLE;
  logic SMM_LOCKED_STATUS, MEMORY_OUTPUT_ENABLE_N, m_wr;
  logic [4:0] BOARD_ROW_STROBE_N, m_rows, m_ref;
  logic [7:0] COL_STROBE_N, m_lanes;
  logic [11:0] MUX_MEM_ADDR, m_ra, m_ca;
  logic [63:0] c;
  int m_refs, miscompares = 0, checks = 0, lat, base;
  logic [31:0] addrs [5] = '{32'h00123458, 32'h00F00008, 32'h01FFFFF8,
    32'h02000000, 32'h03A5A5F8};
  // hole,mgmt,active,pci | map3,fwd,uncached,write | address
  logic [63:0] cases [16] = '{64'h1000_7110_00080000,
    64'h2000_7110_00F00000, 64'h0000_7000_00F00000, 64'h0000_7110_04000000,
    64'h0000_0110_000D0000, 64'h0000_3010_000D0000, 64'h0000_1111_000D0000,
    64'h0000_2011_000D0000, 64'h0000_7000_000D0000, 64'h0200_7010_000A0000,
    64'h0201_7110_000A0000, 64'h0100_7110_000A0000, 64'h0110_7010_000A0000,
    64'h0000_7110_000A0000, 64'h0310_7010_000A0000, 64'h0200_7110_000A0000};
  dima_controller #(.REFRESH_CYCLES_P(40)) dut_u (.*);
  dima_dram_model mem_u (.clk(CLK), .row_n(BOARD_ROW_STROBE_N),
    .col_n(COL_STROBE_N), .oe_n(MEMORY_OUTPUT_ENABLE_N), .ma(MUX_MEM_ADDR),
    .rows(m_rows), .row_addr(m_ra), .col_addr(m_ca), .lanes(m_lanes),
    .wr(m_wr), .ref_rows(m_ref), .refreshes(m_refs));
  always #25 CLK = ~CLK;
  // ----
  // helpers
  // ----
  task automatic tally_and_finish();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic tmo();
    miscompares++;
    $display("ERROR t=%0t wait ran out", $time);
    tally_and_finish();
  endtask
  // lat counts edges from take to the visible done pulse
  task automatic acc(input logic [31:0] ad, input logic w, p,
    input logic [7:0] be);
    int n;
    ACCESS_ADDR = ad;
    ACCESS_WRITE = w;
    ACCESS_PCI = p;
    ACCESS_BE = be;
    ACCESS_REQ = 1'b1;
    n = 0;
    while (ACCESS_READY !== 1'b1)
    begin
      @(posedge CLK) #2;
      if (++n > 50) tmo();
    end
    @(posedge CLK) #2;
    ACCESS_REQ = 1'b0;
    lat = 1;
    while (ACCESS_DONE !== 1'b1)
    begin
      @(posedge CLK) #2;
      if (++lat > 30) tmo();
    end
  endtask
  function automatic logic [4:0] exp_row(input logic [31:0] ad);
    logic [7:0] b [5];
    b = '{ROW_BOUNDARY0, ROW_BOUNDARY1, ROW_BOUNDARY2, ROW_BOUNDARY3,
      ROW_BOUNDARY4};
    for (int i = 0; i < 5; i++)
      if (ad < {4'h0, b[i], 20'h0})
        return 5'(1 << i);
    return 5'h00;
  endfunction
  // ----
  // tests
  // ----
  initial
  begin
    repeat (4) @(posedge CLK);
    #2;
    RESET_N = 1'b1;
    foreach (addrs[i])
    begin
      a = addrs[i];
      acc(a, 1'b1, 1'b0, 8'h5A);
      chk({m_wr, m_lanes}, 9'h15A);
      acc(a, 1'b0, 1'b0, 8'h5A);
      chk({m_wr, m_lanes}, 9'h0FF);
      chk(m_rows, exp_row(a));
      chk(m_ra, {a[24:23], a[21:12]});
      chk(m_ca, {1'b0, a[24], a[22], a[11:3]});
      chk({FORWARD_PCI, NON_CACHEABLE}, 2'b00);
    end
    $display("test address map done");
    acc(32'h0, 1'b0, 1'b0, 8'hFF);
    base = lat;
    acc(32'h00800000, 1'b0, 1'b0, 8'hFF);
    chk(lat, base + 1);
    RAS_TIMING = 2'h2;
    CAS_RATE = 2'h1;
    acc(32'h0, 1'b0, 1'b0, 8'hFF);
    chk(lat, base + 3);
    $display("test timing done");
    foreach (cases[i])
    begin
      c = cases[i];
      HOLE_SEL = c[61:60];
      SYSTEM_MGMT_MEMORY_CTRL = c[57:56];
      SMM_ACTIVE = c[52];
      ATTRIBUTE_MAP3 = c[46:44];
      acc(c[31:0], c[32], c[48], 8'hFF);
      chk(FORWARD_PCI, c[40]);
      chk(NON_CACHEABLE, c[36]);
    end
    chk(SMM_LOCKED_STATUS, 1'b1);
    ROW_BOUNDARY4 = 8'hC0;
    acc(32'h08000000, 1'b0, 1'b0, 8'hFF);
    chk(FORWARD_PCI, 1'b1);
    acc(32'h07FFFFF8, 1'b0, 1'b0, 8'hFF);
    chk(FORWARD_PCI, 1'b0);
    chk(m_rows, 5'h10);
    ROW_BOUNDARY4 = 8'h40;
    $display("test decode done");
    ACCESS_ADDR = 32'h04000000;
    ACCESS_REQ = 1'b1;
    repeat (400)
    begin
      @(posedge CLK) #2;
      if (REFRESH_PENDING === 3'h4)
        full = 1'b1;
    end
    ACCESS_REQ = 1'b0;
    chk(full, 1'b1);
    chk(m_refs > 0, 1'b1);
    chk(m_ref, 5'h1B);
    $display("test refresh done");
    tally_and_finish();
  end
endmodule
